// ==== shared/mmd_map.svh ====
// Offsets, region bounds, field masks and reset values for the memory map decoder.
// Assumes an include by bare name from the decoder module.
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

// ----------------------------------------
// I/O register indexes (byte address = 4 x index)
// ----------------------------------------
`define MMD_IDX_PORT_A_DATA 4'h0
`define MMD_IDX_PORT_B_DATA 4'h1
`define MMD_IDX_PORT_C_DATA 4'h2
`define MMD_IDX_PORT_D_DATA 4'h3
`define MMD_IDX_PORT_A_DIR 4'h4
`define MMD_IDX_PORT_B_DIR 4'h5
`define MMD_IDX_PORT_C_DIR 4'h6
`define MMD_IDX_PORT_D_DIR 4'h7
`define MMD_IDX_PORT_E_DATA 4'h8
`define MMD_IDX_RSVD_NINE 4'h9
`define MMD_IDX_PORT_E_DIR 4'hA
`define MMD_IDX_BACK_EMF 4'hB

// ----------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------
`define MMD_MASK_PORT_A 8'h7F
`define MMD_MASK_PORT_B 8'hFF
`define MMD_MASK_PORT_C 8'h1F
`define MMD_MASK_PORT_D 8'h03
`define MMD_MASK_PORT_E 8'h03
`define MMD_MASK_DIR_C 8'h9F
`define MMD_BIT_CLK_OUT_EN 7
`define MMD_RST_DIR 8'h00

// ----------------------------------------
// CPU address map bounds
// ----------------------------------------
`define MMD_IO_LO 16'h0000
`define MMD_IO_HI 16'h003F
`define MMD_RAM_LO 16'h0040
`define MMD_RAM_HI 16'h023F
`define MMD_BURN_LO 16'h0800
`define MMD_BURN_HI 16'h0BFF
`define MMD_FLASH_LO 16'hC000
`define MMD_FLASH_HI 16'hFDFF
`define MMD_SYS_RSVD_LO 16'hFE0D
`define MMD_SYS_RSVD_HI 16'hFE1F
`define MMD_MON_LO 16'hFE20
`define MMD_MON_HI 16'hFF55
`define MMD_FLASH_PROT 16'hFF7E
`define MMD_OSC_TRIM 16'hFF80
`define MMD_VEC_LO 16'hFFDC
`define MMD_VEC_HI 16'hFFFF
`define MMD_SEC_LO 16'hFFF6
`define MMD_SEC_HI 16'hFFFD
`define MMD_IO_RSVD 16'h0009
`define MMD_IO_LAST_REG 16'h000B

// ----------------------------------------
// System page slots (low nibble within FE0x)
// ----------------------------------------
`define MMD_SYS_PAGE 12'hFE0
`define MMD_SYS_BREAK_STATE 4'h0
`define MMD_SYS_RESET_CAUSE 4'h1
`define MMD_SYS_BREAK_FLAG 4'h3
`define MMD_SYS_FLASH_CTRL 4'h8
`define MMD_SYS_BKPT_HIGH 4'h9
`define MMD_SYS_BKPT_LOW 4'hA
`define MMD_SYS_BKPT_CTRL 4'hB
`define MMD_SYS_LOW_VOLT 4'hC

`endif

// ==== shared/mmd_pkg.sv ====
// Types used only by the memory map decoder; the bench does not import them.
// Assumes mmd_map.svh carries all numeric constants.
package mmd_pkg;

    typedef enum logic [3:0] {
        MMD_RGN_IO,
        MMD_RGN_RAM,
        MMD_RGN_FLASH,
        MMD_RGN_BURNIN,
        MMD_RGN_MONITOR,
        MMD_RGN_SYSREG,
        MMD_RGN_VECTOR,
        MMD_RGN_RESERVED,
        MMD_RGN_UNIMPL
    } mmd_region_e;

endpackage : mmd_pkg

// ==== rtl/mmd_decode.sv ====
// Memory map decoder for a 64-Kbyte 8-bit CPU space, plus the first
// sheet of zero-page I/O registers behind an Avalon-MM slave.
// Assumes CPU address strobes on i_sys_clk; port pins are asynchronous.
//
// Overview of operation
// - Decode the full 16-bit, 64-Kbyte space
// - Flag unimplemented accesses for illegal-address reset
// - Zero-page registers decode at 0000-003F
// - Map holds a 512-byte RAM
// - Map holds a 15,872-byte FLASH array
// - 36 vector bytes end at FFFF
// - 310-byte monitor ROM from FE20
// - 1024-byte burn-in ROM region
// - Security bytes FFF6 through FFFD
// - System registers decode outside zero page
// - Optional trim value readable at FF80
// - Port A data survives reset, bit7 zero
`include "mmd_map.svh"
`timescale 1ns/1ps

module mmd_decode #(
    parameter bit TRIM_PRESENT = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Avalon-MM register slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // CPU address decode port
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_cpu_valid,
    output logic o_sel_io,
    output logic o_sel_ram,
    output logic o_sel_flash,
    output logic o_sel_burnin,
    output logic o_sel_monitor,
    output logic o_sel_sysreg,
    output logic o_sel_vector,
    output logic o_security_byte,
    output logic o_illegal_addr,
    output logic o_reserved_hit,
    // Port pins
    input wire logic [6:0] i_port_a_pin,
    input wire logic [7:0] i_port_b_pin,
    input wire logic [4:0] i_port_c_pin,
    input wire logic [1:0] i_port_d_pin,
    input wire logic [1:0] i_port_e_pin,
    output logic [6:0] o_port_a_out,
    output logic [7:0] o_port_b_out,
    output logic [4:0] o_port_c_out,
    output logic [1:0] o_port_d_out,
    output logic [1:0] o_port_e_out,
    output logic [6:0] o_port_a_oe,
    output logic [7:0] o_port_b_oe,
    output logic [4:0] o_port_c_oe,
    output logic [1:0] o_port_d_oe,
    output logic [1:0] o_port_e_oe,
    output logic o_clock_out_pin_enable,
    // Back-EMF counter value from its own block
    input wire logic [7:0] i_back_emf_count
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic mmd_pkg::mmd_region_e region_of(input logic [15:0] a);
        mmd_pkg::mmd_region_e r;
        r = mmd_pkg::MMD_RGN_UNIMPL;
        if (a <= `MMD_IO_HI)
        begin
            // Beyond the last sheet-one register the zero page is still I/O space
            if (a == `MMD_IO_RSVD)
                r = mmd_pkg::MMD_RGN_RESERVED;
            else
                r = mmd_pkg::MMD_RGN_IO;
        end
        else if (a >= `MMD_RAM_LO && a <= `MMD_RAM_HI)
            r = mmd_pkg::MMD_RGN_RAM;
        else if (a >= `MMD_BURN_LO && a <= `MMD_BURN_HI)
            r = mmd_pkg::MMD_RGN_BURNIN;
        else if (a >= `MMD_FLASH_LO && a <= `MMD_FLASH_HI)
            r = mmd_pkg::MMD_RGN_FLASH;
        else if (a >= `MMD_MON_LO && a <= `MMD_MON_HI)
            r = mmd_pkg::MMD_RGN_MONITOR;
        else if (a >= `MMD_VEC_LO)
            r = mmd_pkg::MMD_RGN_VECTOR;
        else if (a >= `MMD_SYS_RSVD_LO && a <= `MMD_SYS_RSVD_HI)
            r = mmd_pkg::MMD_RGN_RESERVED;
        else if (a == `MMD_FLASH_PROT)
            r = mmd_pkg::MMD_RGN_SYSREG;
        else if (a == `MMD_OSC_TRIM && TRIM_PRESENT)
            r = mmd_pkg::MMD_RGN_SYSREG;
        else if (a[15:4] == `MMD_SYS_PAGE)
        begin
            // Holes in the system page are reserved, not unimplemented
            unique case (a[3:0])
                `MMD_SYS_BREAK_STATE,
                `MMD_SYS_RESET_CAUSE,
                `MMD_SYS_BREAK_FLAG,
                `MMD_SYS_FLASH_CTRL,
                `MMD_SYS_BKPT_HIGH,
                `MMD_SYS_BKPT_LOW,
                `MMD_SYS_BKPT_CTRL,
                `MMD_SYS_LOW_VOLT:
                    r = mmd_pkg::MMD_RGN_SYSREG;
                default:
                    r = mmd_pkg::MMD_RGN_RESERVED;
            endcase
        end
        return r;
    endfunction : region_of

    // Pin value where the line is an input, latch value where it drives
    function automatic logic [7:0] pin_view(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] pin,
        input logic [7:0] mask
    );
        return ((dir & latch) | (~dir & pin)) & mask;
    endfunction : pin_view

    // ----------------------------------------
    // CPU address decode
    // ----------------------------------------
    mmd_pkg::mmd_region_e cpu_rgn;
    logic sel_io_ff;
    logic sel_ram_ff;
    logic sel_flash_ff;
    logic sel_burnin_ff;
    logic sel_monitor_ff;
    logic sel_sysreg_ff;
    logic sel_vector_ff;
    logic security_ff;
    logic illegal_ff;
    logic reserved_ff;

    assign cpu_rgn = region_of(i_cpu_addr);

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sel_io_ff <= 1'b0;
            sel_ram_ff <= 1'b0;
            sel_flash_ff <= 1'b0;
            sel_burnin_ff <= 1'b0;
            sel_monitor_ff <= 1'b0;
            sel_sysreg_ff <= 1'b0;
            sel_vector_ff <= 1'b0;
        end
        else
        begin
            // One-hot by construction of the enum compare
            sel_io_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_IO;
            sel_ram_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_RAM;
            sel_flash_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_FLASH;
            sel_burnin_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_BURNIN;
            sel_monitor_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_MONITOR;
            sel_sysreg_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_SYSREG;
            sel_vector_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_VECTOR;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            security_ff <= 1'b0;
            illegal_ff <= 1'b0;
            reserved_ff <= 1'b0;
        end
        else
        begin
            security_ff <= i_cpu_valid && i_cpu_addr >= `MMD_SEC_LO
                && i_cpu_addr <= `MMD_SEC_HI;
            illegal_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_UNIMPL;
            // Reported only; behaviour there is left undefined for the master
            reserved_ff <= i_cpu_valid && cpu_rgn == mmd_pkg::MMD_RGN_RESERVED;
        end
    end

    // ----------------------------------------
    // Region outputs
    // ----------------------------------------

    assign o_sel_io = sel_io_ff;
    assign o_sel_ram = sel_ram_ff;
    assign o_sel_flash = sel_flash_ff;
    assign o_sel_burnin = sel_burnin_ff;
    assign o_sel_monitor = sel_monitor_ff;
    assign o_sel_sysreg = sel_sysreg_ff;
    assign o_sel_vector = sel_vector_ff;
    assign o_security_byte = security_ff;
    assign o_illegal_addr = illegal_ff;
    assign o_reserved_hit = reserved_ff;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [23:0] pin_s1_ff;
    logic [23:0] pin_s2_ff;
    logic [23:0] pin_raw;

    // Zero reset keeps pin reads defined before two edges have passed
    assign pin_raw = {i_port_e_pin, i_port_d_pin, i_port_c_pin,
        i_port_b_pin, i_port_a_pin};

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_s1_ff <= 24'h000000;
            pin_s2_ff <= 24'h000000;
        end
        else
        begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ----------------------------------------
    // Avalon handshake: one wait state
    // ----------------------------------------
    logic ack_ff;
    logic req;
    logic take;
    logic [3:0] idx;
    logic wr_en;

    assign req = i_avs_read | i_avs_write;
    assign take = req & ~ack_ff;
    assign idx = i_avs_address[5:2];
    // Only the low byte lane carries the 8-bit registers
    assign wr_en = take & i_avs_write & i_avs_byteenable[0];
    assign o_avs_waitrequest = req & ~ack_ff;

    // Registers act on the take edge; the master holds the request past it
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ack_ff <= 1'b0;
        else
            ack_ff <= take;
    end

    // ----------------------------------------
    // Port registers
    // ----------------------------------------
    logic [7:0] a_data_ff;
    logic [7:0] b_data_ff;
    logic [7:0] c_data_ff;
    logic [7:0] d_data_ff;
    logic [7:0] e_data_ff;
    logic [7:0] a_dir_ff;
    logic [7:0] b_dir_ff;
    logic [7:0] c_dir_ff;
    logic [7:0] d_dir_ff;
    logic [7:0] e_dir_ff;
    logic [7:0] wbyte;

    assign wbyte = i_avs_writedata[7:0];

    // Data latches have no reset so pin levels survive a reset
    always_ff @(posedge i_sys_clk)
    begin
        if (wr_en)
        begin
            unique case (idx)
                `MMD_IDX_PORT_A_DATA: a_data_ff <= wbyte & `MMD_MASK_PORT_A;
                `MMD_IDX_PORT_B_DATA: b_data_ff <= wbyte;
                `MMD_IDX_PORT_C_DATA: c_data_ff <= wbyte & `MMD_MASK_PORT_C;
                `MMD_IDX_PORT_D_DATA: d_data_ff <= wbyte & `MMD_MASK_PORT_D;
                `MMD_IDX_PORT_E_DATA: e_data_ff <= wbyte & `MMD_MASK_PORT_E;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            a_dir_ff <= `MMD_RST_DIR;
            b_dir_ff <= `MMD_RST_DIR;
            c_dir_ff <= `MMD_RST_DIR;
            d_dir_ff <= `MMD_RST_DIR;
            e_dir_ff <= `MMD_RST_DIR;
        end
        else if (wr_en)
        begin
            unique case (idx)
                `MMD_IDX_PORT_A_DIR: a_dir_ff <= wbyte & `MMD_MASK_PORT_A;
                `MMD_IDX_PORT_B_DIR: b_dir_ff <= wbyte;
                `MMD_IDX_PORT_C_DIR: c_dir_ff <= wbyte & `MMD_MASK_DIR_C;
                `MMD_IDX_PORT_D_DIR: d_dir_ff <= wbyte & `MMD_MASK_PORT_D;
                `MMD_IDX_PORT_E_DIR: e_dir_ff <= wbyte & `MMD_MASK_PORT_E;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] rd_byte;
    logic [31:0] rdata_ff;

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (idx)
            `MMD_IDX_PORT_A_DATA:
                rd_byte = pin_view(a_dir_ff, a_data_ff, {1'b0, pin_s2_ff[6:0]},
                    `MMD_MASK_PORT_A);
            `MMD_IDX_PORT_B_DATA:
                rd_byte = pin_view(b_dir_ff, b_data_ff, pin_s2_ff[14:7],
                    `MMD_MASK_PORT_B);
            `MMD_IDX_PORT_C_DATA:
                rd_byte = pin_view(c_dir_ff, c_data_ff, {3'b000, pin_s2_ff[19:15]},
                    `MMD_MASK_PORT_C);
            `MMD_IDX_PORT_D_DATA:
                rd_byte = pin_view(d_dir_ff, d_data_ff, {6'b000000, pin_s2_ff[21:20]},
                    `MMD_MASK_PORT_D);
            `MMD_IDX_PORT_E_DATA:
                rd_byte = pin_view(e_dir_ff, e_data_ff, {6'b000000, pin_s2_ff[23:22]},
                    `MMD_MASK_PORT_E);
            `MMD_IDX_PORT_A_DIR: rd_byte = a_dir_ff;
            `MMD_IDX_PORT_B_DIR: rd_byte = b_dir_ff;
            `MMD_IDX_PORT_C_DIR: rd_byte = c_dir_ff;
            `MMD_IDX_PORT_D_DIR: rd_byte = d_dir_ff;
            `MMD_IDX_PORT_E_DIR: rd_byte = e_dir_ff;
            `MMD_IDX_BACK_EMF: rd_byte = i_back_emf_count;
            // Reserved slot and unmapped indexes answer zero
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rdata_ff <= 32'h00000000;
        else if (take & i_avs_read)
            rdata_ff <= {24'h000000, rd_byte};
    end

    assign o_avs_readdata = rdata_ff;

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    assign o_port_a_out = a_data_ff[6:0];
    assign o_port_b_out = b_data_ff;
    assign o_port_c_out = c_data_ff[4:0];
    assign o_port_d_out = d_data_ff[1:0];
    assign o_port_e_out = e_data_ff[1:0];
    assign o_port_a_oe = a_dir_ff[6:0];
    assign o_port_b_oe = b_dir_ff;
    assign o_port_c_oe = c_dir_ff[4:0];
    assign o_port_d_oe = d_dir_ff[1:0];
    assign o_port_e_oe = e_dir_ff[1:0];
    assign o_clock_out_pin_enable = c_dir_ff[`MMD_BIT_CLK_OUT_EN];

endmodule : mmd_decode

// ==== tb/mmd_cpu_model.sv ====
// CPU-side partner: issues one-cycle address accesses to the decoder.
// Assumes the bench calls access() and samples selects after it returns.
`timescale 1ns/1ps

module mmd_cpu_model (
    input wire logic i_clk,
    output logic [15:0] o_addr,
    output logic o_valid
);
    initial
    begin
        o_addr = 16'hFFFF;
        o_valid = 1'b0;
    end

    // Reserved places are visited only when the bench asks for them
    task automatic access(input logic [15:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_valid <= 1'b1;
        @(posedge i_clk);
        o_valid <= 1'b0;
        // Released bus must not keep showing the old address
        o_addr <= ~a;
    endtask : access
endmodule : mmd_cpu_model

// ==== tb/mmd_decode_sva.sv ====
// Checker for the memory map decoder, bound to its top module.
// Assumes registered selects one cycle after a valid CPU address.
`timescale 1ns/1ps
`include "mmd_map.svh"

module mmd_decode_sva #(
    parameter bit TRIM_PRESENT = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [31:0] o_avs_readdata,
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_cpu_valid,
    input wire logic o_sel_io,
    input wire logic o_sel_ram,
    input wire logic o_sel_flash,
    input wire logic o_sel_burnin,
    input wire logic o_sel_monitor,
    input wire logic o_sel_sysreg,
    input wire logic o_sel_vector,
    input wire logic o_security_byte,
    input wire logic o_illegal_addr,
    input wire logic o_reserved_hit
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    wire [8:0] one_of = {o_sel_io, o_sel_ram, o_sel_flash, o_sel_burnin, o_sel_monitor,
        o_sel_sysreg, o_sel_vector, o_illegal_addr, o_reserved_hit};

    property p_map(lo, hi, s);
        i_cpu_valid && i_cpu_addr >= lo && i_cpu_addr <= hi |=> s;
    endproperty

    chk_io_window: assert property (i_cpu_valid && i_cpu_addr <= `MMD_IO_HI
        && i_cpu_addr != `MMD_IO_RSVD |=> o_sel_io) else $error("io select missing");
    chk_ram_region: assert property (p_map(`MMD_RAM_LO, `MMD_RAM_HI, o_sel_ram))
        else $error("ram select missing");
    chk_flash_user: assert property (p_map(`MMD_FLASH_LO, `MMD_FLASH_HI, o_sel_flash))
        else $error("flash select missing");
    chk_vector_top: assert property (p_map(`MMD_VEC_LO, `MMD_VEC_HI, o_sel_vector))
        else $error("vector select missing");
    chk_monitor_rom: assert property (p_map(`MMD_MON_LO, `MMD_MON_HI, o_sel_monitor))
        else $error("monitor select missing");
    chk_burnin_rom: assert property (p_map(`MMD_BURN_LO, `MMD_BURN_HI, o_sel_burnin))
        else $error("burn-in select missing");
    chk_security_bytes: assert property (i_cpu_valid |=>
        o_security_byte == ($past(i_cpu_addr) inside {[`MMD_SEC_LO:`MMD_SEC_HI]}))
        else $error("security flag wrong");
    chk_sysreg_high: assert property (i_cpu_valid
        && i_cpu_addr inside {16'hFE01, 16'hFE08, 16'hFF7E} |=> o_sel_sysreg)
        else $error("system register select missing");
    chk_trim_read: assert property (i_cpu_valid && i_cpu_addr == `MMD_OSC_TRIM
        |=> o_sel_sysreg == TRIM_PRESENT) else $error("trim select wrong");
    chk_illegal_gap: assert property (p_map(16'hFF56, 16'hFF7D, o_illegal_addr))
        else $error("illegal flag missing");
    chk_one_select: assert property (i_cpu_valid |=> $onehot(one_of))
        else $error("select count not one");
    chk_idle_quiet: assert property (!i_cpu_valid
        |=> one_of == 9'h000 && !o_security_byte) else $error("select without access");
    chk_readdata_upper: assert property (o_avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits set");

    cover property (i_cpu_valid ##1 o_security_byte);
    cover property (i_cpu_valid ##1 o_illegal_addr);
    cover property (i_cpu_valid ##1 o_reserved_hit);
endmodule : mmd_decode_sva

bind mmd_decode mmd_decode_sva #(.TRIM_PRESENT(TRIM_PRESENT)) u_sva (.i_sys_clk, .i_rstn,
    .o_avs_readdata, .i_cpu_addr, .i_cpu_valid, .o_sel_io, .o_sel_ram, .o_sel_flash,
    .o_sel_burnin, .o_sel_monitor, .o_sel_sysreg, .o_sel_vector, .o_security_byte,
    .o_illegal_addr, .o_reserved_hit);

// ==== tb/tb_top.sv ====
// Bench for the memory map decoder: CPU decode table plus register access.
// Assumes one Avalon wait state at most in practice; every wait is bounded.
`timescale 1ns/1ps

module tb_top;
    logic clk, rstn, rd, wr, wreq;
    logic [5:0] adr;
    logic [31:0] wd, rdata;
    logic [15:0] caddr;
    logic cval;
    logic [6:0] pa;
    logic [3:0] be;
    wire [23:0] pout, poe;
    logic [7:0] pb, back_emf_count, q;
    logic [4:0] pc;
    logic [1:0] pd, pe;
    logic cken;
    wire [9:0] sel;
    int n_fail = 0;
    int check_count = 0;
    // Expected {io,ram,flash,burn,mon,sys,vec,sec,ill,rsv}
    logic [15:0] ta [25] = '{16'h0000, 16'h0009, 16'h003F, 16'h0040, 16'h023F, 16'h0240,
        16'h0800, 16'h0BFF, 16'h0C00, 16'hC000, 16'hFDFF, 16'hFE01, 16'hFE02, 16'hFE08,
        16'hFE0D, 16'hFE20, 16'hFF55, 16'hFF56, 16'hFF7E, 16'hFF80, 16'hFFDB, 16'hFFDC,
        16'hFFF6, 16'hFFFD, 16'hFFFE};
    logic [9:0] te [25] = '{10'h200, 10'h001, 10'h200, 10'h100, 10'h100, 10'h002, 10'h040,
        10'h040, 10'h002, 10'h080, 10'h080, 10'h010, 10'h001, 10'h010, 10'h001, 10'h020,
        10'h020, 10'h002, 10'h010, 10'h010, 10'h002, 10'h008, 10'h00C, 10'h00C, 10'h008};
    logic [3:0] di [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
    logic [3:0] ddi [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hA};
    logic [7:0] dm [5] = '{8'h7F, 8'hFF, 8'h9F, 8'h03, 8'h03};
    logic [7:0] m [5] = '{8'h7F, 8'hFF, 8'h1F, 8'h03, 8'h03};
    logic [7:0] pv [5] = '{8'h55, 8'h3C, 8'h0A, 8'h01, 8'h02};

    mmd_decode #(.TRIM_PRESENT(1'b1)) uut (.i_sys_clk(clk), .i_rstn(rstn),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
        .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_cpu_addr(caddr), .i_cpu_valid(cval), .o_sel_io(sel[9]), .o_sel_ram(sel[8]),
        .o_sel_flash(sel[7]), .o_sel_burnin(sel[6]), .o_sel_monitor(sel[5]),
        .o_sel_sysreg(sel[4]), .o_sel_vector(sel[3]), .o_security_byte(sel[2]),
        .o_illegal_addr(sel[1]), .o_reserved_hit(sel[0]), .i_port_a_pin(pa),
        .i_port_b_pin(pb), .i_port_c_pin(pc), .i_port_d_pin(pd), .i_port_e_pin(pe),
        .o_port_a_out(pout[6:0]), .o_port_b_out(pout[14:7]), .o_port_c_out(pout[19:15]),
        .o_port_d_out(pout[21:20]), .o_port_e_out(pout[23:22]), .o_port_a_oe(poe[6:0]),
        .o_port_b_oe(poe[14:7]), .o_port_c_oe(poe[19:15]), .o_port_d_oe(poe[21:20]),
        .o_port_e_oe(poe[23:22]), .o_clock_out_pin_enable(cken), .i_back_emf_count(back_emf_count));

    mmd_cpu_model cpu (.i_clk(clk), .o_addr(caddr), .o_valid(cval));

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic av(input bit w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {24'h000000, d};
        do
        begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0)
        begin
            n_fail++;
            close_out;
        end
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        rstn = 1'b0; rd = 1'b0; wr = 1'b0; adr = 6'h00; wd = 32'h00000000;
        pa = 7'h55; pb = 8'h3C; pc = 5'h0A; pd = 2'h1; pe = 2'h2; back_emf_count = 8'hA5;
        be = 4'hF;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // --------------------------------
        // CPU map walk, one idle cycle between accesses
        // --------------------------------
        for (int i = 0; i < 25; i++)
        begin
            cpu.access(ta[i]);
            #1 chk("region select", {6'h00, sel}, {6'h00, te[i]});
        end
        // --------------------------------
        // Register bank
        // --------------------------------
        for (int i = 0; i < 5; i++)
        begin
            av(0, ddi[i], 8'h00);
            chk("direction reset", {8'h00, q}, 16'h0000);
            av(0, di[i], 8'h00);
            chk("pin read", {8'h00, q}, {8'h00, pv[i]});
            av(1, ddi[i], 8'hFF);
            av(1, di[i], 8'hFF);
            av(0, ddi[i], 8'h00);
            chk("direction mask", {8'h00, q}, {8'h00, dm[i]});
            av(0, di[i], 8'h00);
            chk("data mask", {8'h00, q}, {8'h00, m[i]});
        end
        chk("clock out enable", {15'h0000, cken}, 16'h0001);
        // Slot 9 is reserved, so the master never touches it
        be <= 4'hE;
        av(1, 4'h1, 8'h00);
        be <= 4'hF;
        av(0, 4'h1, 8'h00);
        chk("masked lane write", {8'h00, q}, 16'h00FF);
        av(0, 4'hF, 8'h00);
        chk("unmapped slot", {8'h00, q}, 16'h0000);
        av(1, 4'hB, 8'h00);
        av(0, 4'hB, 8'h00);
        chk("back emf", {8'h00, q}, 16'h00A5);
        chk("port drive low", pout[15:0], 16'hFFFF);
        chk("port drive high", {8'h00, pout[23:16]}, 16'h00FF);
        chk("port enable low", poe[15:0], 16'hFFFF);
        chk("port enable high", {8'h00, poe[23:16]}, 16'h00FF);
        // Mid-run reset: data latch must survive, direction must clear
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk("port a latch", {9'h000, pout[6:0]}, 16'h007F);
        chk("enable after reset low", poe[15:0], 16'h0000);
        chk("enable after reset high", {8'h00, poe[23:16]}, 16'h0000);
        chk("clock out after reset", {15'h0000, cken}, 16'h0000);
        av(0, 4'h4, 8'h00);
        chk("direction after reset", {8'h00, q}, 16'h0000);
        close_out;
    end
endmodule : tb_top
